// ---- logic/spim_pkg.sv ----
// Shared constants and types for the serial peripheral port
`default_nettype none

package spim_pkg;

    localparam int unsigned PCLK_HZ   = 20_000_000;
    localparam int unsigned DATA_BITS = 8;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] BUF_OFS  = 8'h08;
    localparam logic [7:0] FLAG_OFS = 8'h0c;
    localparam logic [7:0] PIN_OFS  = 8'h10;

    // Field positions
    localparam int unsigned CTRL_COLL_BIT = 7;
    localparam int unsigned CTRL_EN_BIT   = 5;
    localparam int unsigned CTRL_CPOL_BIT = 4;
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned STAT_PHS_BIT  = 7;
    localparam int unsigned STAT_CKE_BIT  = 6;
    localparam int unsigned STAT_FULL_BIT = 0;
    localparam int unsigned FLAG_IF_BIT   = 0;
    localparam int unsigned PIN_SDO_BIT   = 0;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] PIN_RST  = 8'h00;
    localparam logic [7:0] BUF_RST  = 8'h00;

    // Bit clock dividers of the oscillator
    localparam int unsigned DIV_FAST = 4;
    localparam int unsigned DIV_MID  = 16;
    localparam int unsigned DIV_SLOW = 64;
    localparam logic [5:0]  HALF_FAST = 6'(DIV_FAST / 2);
    localparam logic [5:0]  HALF_MID  = 6'(DIV_MID / 2);
    localparam logic [5:0]  HALF_SLOW = 6'(DIV_SLOW / 2);

    // Half-bit events per byte
    localparam logic [4:0] LAST_EVT  = 5'(2 * DATA_BITS);
    localparam logic [4:0] SLAVE_END = 5'(2 * DATA_BITS - 1);

    typedef enum logic [3:0] {
        MODE_M_DIV4  = 4'b0000,
        MODE_M_DIV16 = 4'b0001,
        MODE_M_DIV64 = 4'b0010,
        MODE_M_TIMER = 4'b0011,
        MODE_S_SEL   = 4'b0100,
        MODE_S_NOSEL = 4'b0101
    } spim_mode_e;

    typedef enum logic {
        ST_IDLE  = 1'b0,
        ST_SHIFT = 1'b1
    } spim_state_e;

    function automatic logic [5:0] spim_half(input logic [1:0] sel);
        logic [5:0] h;
        h = HALF_FAST;
        case (sel)
            2'b01:   h = HALF_MID;
            2'b10:   h = HALF_SLOW;
            default: h = HALF_FAST;
        endcase
        return h;
    endfunction : spim_half

endpackage : spim_pkg

`default_nettype wire

// ---- logic/spim_rate_gen.sv ----
// Half-bit enable pulse generator for master bit clock
`default_nettype none

module spim_rate_gen
    import spim_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic [1:0] rate_sel,
    input  wire logic       timer_tick,
    output logic            half_tick
);

    logic [5:0] cnt_reg;
    logic [5:0] half_w;
    logic       wrap_w;

    assign half_w = spim_half(rate_sel);
    assign wrap_w = (cnt_reg == half_w - 6'h01);

    // Timer source: one half bit per timer pulse gives timer/2
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg   <= 6'h00;
            half_tick <= 1'b0;
        end
        else if (!run)
        begin
            cnt_reg   <= 6'h00;
            half_tick <= 1'b0;
        end
        else if (rate_sel == 2'b11)
        begin
            cnt_reg   <= 6'h00;
            half_tick <= timer_tick;
        end
        else
        begin
            cnt_reg   <= wrap_w ? 6'h00 : cnt_reg + 6'h01;
            half_tick <= wrap_w;
        end
    end

endmodule : spim_rate_gen

`default_nettype wire

// ---- logic/spim_shifter.sv ----
// Serial shift register, reached only through the transfer buffer
`default_nettype none

module spim_shifter #(
    parameter int unsigned W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         load,
    input  wire logic [W-1:0] load_data,
    input  wire logic         shift,
    input  wire logic         shift_in,
    output logic [W-1:0]      data
);

    // Msb leaves first, new bit enters at the lsb
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            data <= '0;
        else if (load)
            data <= load_data;
        else if (shift)
            data <= {data[W-2:0], shift_in};
    end

endmodule : spim_shifter

`default_nettype wire

// ---- logic/spim_port.sv ----
// Byte-wide serial peripheral port with APB register access
//
// Notes on behaviour
// - Every transfer moves eight bits out and eight in through one shifter.
// - Bits travel msb first both ways; the master makes all clocks.
// - Master mode: writing the buffer starts a transfer at once.
// - After bit eight the byte enters the buffer; full and irq flags set.
// - Buffer write during a transfer is dropped and sets the collision flag.
// - Reading the buffer clears the full flag; only reception sets it.
// - The shifter is hidden; software reaches it only through the buffer.
// - Enabled master owns data-in as input, data-out and clock as outputs.
// - Master bit clock is clock/4, /16, /64 or period timer/2.
// - Clock idle polarity sets the idle level of the clock output.
// - Edge select set puts data out before the first clock edge.
// - In master mode the sample phase picks middle or end of the data output time.
// - With data-out disabled, data-in still shifts at the set rate.
// - Sleep in master mode freezes the transfer; it resumes on wake.
// - Slave mode shifts only on clock edges from the external master.
// - Modes: 0000..0011 master rates, 0100 slave with select, 0101 without.
// - Idle polarity one idles the clock high, zero idles it low.
// - Edge select one: data stable on rising edge if idle low; else inverted.
// - In master mode sample phase one samples at end of output time, zero at middle.
`default_nettype none

module spim_port
    import spim_pkg::*;
#(
    parameter int unsigned AW = 8
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          sleep_req,
    input  wire logic          timer_tick,
    input  wire logic          sck_i,
    output logic               sck_o,
    output logic               sck_oe,
    output logic               sdo_o,
    output logic               sdo_oe,
    input  wire logic          sdi_i,
    input  wire logic          ss_n_i
);

    ////////////////////////////////////////////////////////////////////////
    // State

    spim_state_e state_reg;
    logic [3:0]  mode_reg;
    logic        cpol_reg;
    logic        en_reg;
    logic        coll_reg;
    logic        phs_reg;
    logic        cke_reg;
    logic        full_reg;
    logic        if_reg;
    logic        sdo_off_reg;
    logic [7:0]  buf_reg;
    logic [4:0]  q_reg;
    logic        samp_reg;
    logic        phase_reg;
    logic        sck_prev_reg;
    logic [7:0]  sr_data;
    logic        rate_tick;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic        acc_w;
    logic        wr_w;
    logic        rd_w;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        hit_buf;
    logic        hit_flag;
    logic        hit_pin;
    logic        mapped_w;
    logic [7:0]  rd_mux;
    logic [7:0]  ofs_w;

    assign ofs_w    = 8'(paddr);
    assign acc_w    = psel & penable & pready;
    assign wr_w     = acc_w & pwrite;
    assign rd_w     = acc_w & ~pwrite;
    assign hit_ctrl = (ofs_w == CTRL_OFS);
    assign hit_stat = (ofs_w == STAT_OFS);
    assign hit_buf  = (ofs_w == BUF_OFS);
    assign hit_flag = (ofs_w == FLAG_OFS);
    assign hit_pin  = (ofs_w == PIN_OFS);
    assign mapped_w = hit_ctrl | hit_stat | hit_buf | hit_flag | hit_pin;

    assign rd_mux =
        hit_ctrl ? {coll_reg, 1'b0, en_reg, cpol_reg, mode_reg} :
        hit_stat ? {phs_reg, cke_reg, 5'h00, full_reg} :
        hit_buf  ? buf_reg :
        hit_flag ? {7'h00, if_reg} :
        hit_pin  ? {7'h00, sdo_off_reg} : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Mode and event decode

    logic        master_w;
    logic        slave_w;
    logic        ss_hold_w;
    logic        busy_w;
    logic        started_w;
    logic        buf_wr_w;
    logic        start_w;
    logic        slave_load_w;
    logic        collide_w;
    logic        sck_edge_w;
    logic        tick_w;
    logic        mid_w;
    logic        end_w;
    logic        slave_last_w;
    logic        done_w;
    logic        shift_w;
    logic        shift_in_w;
    logic        toggle_w;
    logic        abort_w;
    logic        arm_w;
    logic [4:0]  q_start_w;
    logic [7:0]  rx_byte_w;

    assign master_w  = (mode_reg[3:2] == 2'b00);
    assign slave_w   = (mode_reg == MODE_S_SEL) |
                       (mode_reg == MODE_S_NOSEL);
    assign ss_hold_w = (mode_reg == MODE_S_SEL) & ss_n_i;
    assign abort_w   = ~en_reg | ss_hold_w | ~(master_w | slave_w);
    assign busy_w    = (state_reg == ST_SHIFT);
    assign q_start_w = {4'h0, cke_reg};
    assign started_w = busy_w & (master_w | (q_reg != q_start_w));

    assign buf_wr_w     = wr_w & hit_buf;
    assign collide_w    = buf_wr_w & started_w;
    assign start_w      = buf_wr_w & ~busy_w & en_reg & master_w;
    assign slave_load_w = buf_wr_w & ~started_w & en_reg & slave_w;
    // Slave waits armed so an early external clock is not missed
    assign arm_w        = ~busy_w & en_reg & slave_w & ~ss_hold_w;

    // Slave edges count only while armed; pins are clock-synchronous
    assign sck_edge_w = slave_w & busy_w & (sck_i != sck_prev_reg);
    assign tick_w     = master_w ? (rate_tick & busy_w) : sck_edge_w;

    // Even count from two up ends a data output time, odd count is its middle
    assign mid_w        = tick_w & q_reg[0];
    assign end_w        = tick_w & ~q_reg[0] & (q_reg >= 5'h02);
    assign slave_last_w = slave_w & tick_w & (q_reg == SLAVE_END);
    assign done_w       = (tick_w & (q_reg == LAST_EVT)) | slave_last_w;
    assign shift_w      = end_w | slave_last_w;
    assign shift_in_w   = ((phs_reg & master_w) | slave_last_w) ?
                          sdi_i : samp_reg;
    assign rx_byte_w    = {sr_data[6:0], shift_in_w};
    // No clock edge on the trailing end-sample event when edge select is 0
    assign toggle_w     = master_w & tick_w &
                          ~((q_reg == LAST_EVT) & ~cke_reg);

    ////////////////////////////////////////////////////////////////////////
    // Bit rate and shifter

    spim_rate_gen u_rate (
        .pclk       (pclk),
        .presetn    (presetn),
        .run        (busy_w & master_w & ~sleep_req & ~abort_w),
        .rate_sel   (mode_reg[1:0]),
        .timer_tick (timer_tick),
        .half_tick  (rate_tick)
    );

    spim_shifter #(
        .W (DATA_BITS)
    ) u_shift (
        .pclk      (pclk),
        .presetn   (presetn),
        .load      (start_w | slave_load_w),
        .load_data (pwdata[7:0]),
        .shift     (shift_w & ~abort_w),
        .shift_in  (shift_in_w),
        .data      (sr_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencer

    spim_state_e state_next;
    logic [4:0]  q_next;

    always_comb
    begin
        state_next = state_reg;
        q_next     = q_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (start_w | arm_w)
                begin
                    state_next = ST_SHIFT;
                    q_next     = q_start_w;
                end
            end
            ST_SHIFT:
            begin
                if (abort_w)
                begin
                    state_next = ST_IDLE;
                    q_next     = 5'h00;
                end
                else if (done_w)
                begin
                    state_next = ST_IDLE;
                    q_next     = 5'h00;
                end
                else if (tick_w)
                    q_next = q_reg + 5'h01;
            end
            default:
            begin
                state_next = ST_IDLE;
                q_next     = 5'h00;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= ST_IDLE;
            q_reg     <= 5'h00;
        end
        else
        begin
            state_reg <= state_next;
            q_reg     <= q_next;
        end
    end

    // Middle-of-bit sample held until the shift at end of bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            samp_reg <= 1'b0;
        else if (mid_w)
            samp_reg <= sdi_i;
    end

    // Clock phase: an even edge count returns it to idle by itself
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            phase_reg <= 1'b0;
        else if (abort_w | ~busy_w)
            phase_reg <= 1'b0;
        else if (toggle_w)
            phase_reg <= ~phase_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_reg    <= CTRL_RST[3:0];
            cpol_reg    <= CTRL_RST[CTRL_CPOL_BIT];
            en_reg      <= CTRL_RST[CTRL_EN_BIT];
            phs_reg     <= STAT_RST[STAT_PHS_BIT];
            cke_reg     <= STAT_RST[STAT_CKE_BIT];
            sdo_off_reg <= PIN_RST[PIN_SDO_BIT];
        end
        else if (wr_w)
        begin
            if (hit_ctrl)
            begin
                mode_reg <= pwdata[CTRL_MODE_LSB +: 4];
                cpol_reg <= pwdata[CTRL_CPOL_BIT];
                en_reg   <= pwdata[CTRL_EN_BIT];
            end
            if (hit_stat)
            begin
                phs_reg <= pwdata[STAT_PHS_BIT];
                cke_reg <= pwdata[STAT_CKE_BIT];
            end
            if (hit_pin)
                sdo_off_reg <= pwdata[PIN_SDO_BIT];
        end
    end

    // Set beats clear on every hardware flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            coll_reg <= 1'b0;
            full_reg <= 1'b0;
            if_reg   <= 1'b0;
        end
        else
        begin
            if (collide_w)
                coll_reg <= 1'b1;
            else if (wr_w & hit_ctrl & ~pwdata[CTRL_COLL_BIT])
                coll_reg <= 1'b0;
            if (done_w & ~abort_w)
                full_reg <= 1'b1;
            else if (rd_w & hit_buf)
                full_reg <= 1'b0;
            if (done_w & ~abort_w)
                if_reg <= 1'b1;
            else if (wr_w & hit_flag & pwdata[FLAG_IF_BIT])
                if_reg <= 1'b0;
        end
    end

    // Collided writes never reach the buffer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            buf_reg <= BUF_RST;
        else if (done_w & ~abort_w)
            buf_reg <= rx_byte_w;
        else if (buf_wr_w & ~collide_w)
            buf_reg <= pwdata[7:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: one wait cycle, all outputs registered

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped_w;
            if (psel & penable & ~pready & ~pwrite)
                prdata <= {24'h00_0000, rd_mux};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sck_o        <= 1'b0;
            sck_oe       <= 1'b0;
            sdo_o        <= 1'b0;
            sdo_oe       <= 1'b0;
            sck_prev_reg <= 1'b0;
        end
        else
        begin
            sck_o        <= cpol_reg ^
                            (toggle_w ? ~phase_reg : phase_reg);
            sck_oe       <= en_reg & master_w;
            sdo_o        <= (start_w | slave_load_w) ? pwdata[7] :
                            shift_w ? sr_data[6] : sr_data[7];
            sdo_oe       <= en_reg & ~sdo_off_reg & ~ss_hold_w &
                            (master_w | slave_w);
            sck_prev_reg <= sck_i;
        end
    end

endmodule : spim_port

`default_nettype wire

// ---- sim/spim_port_chk.sv ----
// Concurrent checks on the port's bus and serial pins
`default_nettype none

module spim_port_chk
    import spim_pkg::*;
#(
    parameter int unsigned AW = 8
) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic          sleep_req,
    input wire logic          timer_tick,
    input wire logic          sck_i,
    input wire logic          sck_o,
    input wire logic          sck_oe,
    input wire logic          sdo_o,
    input wire logic          sdo_oe,
    input wire logic          sdi_i,
    input wire logic          ss_n_i
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////
    // Clock toggles since the last control or buffer write
    logic [5:0] tgl_reg;
    wire        wr_cfg = psel && penable && pready && pwrite
                         && (paddr == AW'(CTRL_OFS) || paddr == AW'(BUF_OFS));

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            tgl_reg <= 6'h0;
        else if (wr_cfg)
            tgl_reg <= 6'h0;
        else if ($changed(sck_o) && tgl_reg != 6'h3f)
            tgl_reg <= tgl_reg + 6'h1;

    ////////////////////////////////////////
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence

    property p_one_wait;
        s_access |=> s_answer;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("bus answer late or too long");
    property p_no_access;
        !(psel && penable) |=> !pready;
    endproperty
    a_no_access: assert property (p_no_access)
        else $error("ready without access");
    property p_bad_addr;
        (s_access and (paddr > AW'(PIN_OFS))) |=> pready && pslverr;
    endproperty
    a_bad_addr: assert property (p_bad_addr)
        else $error("unmapped access not refused");
    property p_good_addr;
        (s_access and (paddr <= AW'(PIN_OFS) && paddr[1:0] == 2'b00))
            |=> !pslverr;
    endproperty
    a_good_addr: assert property (p_good_addr)
        else $error("mapped access refused");
    property p_rd_upper;
        pready && !pwrite |-> prdata[31:8] == 24'h0;
    endproperty
    a_rd_upper: assert property (p_rd_upper)
        else $error("read data upper bits set");
    property p_sleep;
        sleep_req [*4] |-> $stable(sck_o) && $stable(sdo_o);
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("serial pins move during sleep");
    property p_half_bit;
        sck_oe && $changed(sck_o) |=> $stable(sck_o) || !sck_oe;
    endproperty
    a_half_bit: assert property (p_half_bit)
        else $error("serial clock half bit under two cycles");
    property p_byte_len;
        tgl_reg <= 6'd16;
    endproperty
    a_byte_len: assert property (p_byte_len)
        else $error("more than sixteen clock edges per byte");

endmodule : spim_port_chk

bind spim_port spim_port_chk #(.AW(AW)) u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sleep_req, .timer_tick, .sck_i,
    .sck_o, .sck_oe, .sdo_o, .sdo_oe, .sdi_i, .ss_n_i
);

`default_nettype wire

// ---- sim/spim_slave_model.sv ----
// Behavioural serial slave facing the master port
`default_nettype none

module spim_slave_model (
    input  wire logic       sck,
    input  wire logic       sdo,
    input  wire logic       cpol,
    input  wire logic       cke,
    input  wire logic       load,
    input  wire logic [7:0] tx,
    output logic            sdi,
    output logic [7:0]      rx
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] sh;
    logic       got;
    // Sampling edge is rising when edge select and idle level differ
    wire        rise_in = cke ^ cpol;

    ////////////////////////////////////////
    always @(sck or posedge load)
    begin
        if (load)
        begin
            sh = tx;
            got = 1'b0;
        end
        else if (sck == rise_in)
        begin
            rx = {rx[6:0], sdo};
            got = 1'b1;
        end
        else if (got)
        begin
            // Fill with inverted bits so a stale line never looks valid
            sh = {sh[6:0], ~sh[0]};
            got = 1'b0;
        end
    end

    assign sdi = sh[7];

endmodule : spim_slave_model

`default_nettype wire

// ---- sim/tb_spim_port.sv ----
// Self-checking bench: table of transfers, then odd cases
`default_nettype none

module tb_spim_port
    import spim_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [3:0] mode;
        logic       pol;
        logic       edg;
        logic       phs;
        logic       dis;
        logic [7:0] tx;
        logic [7:0] rx;
    } spim_row_s;

    logic        pclk = 1'b0;
    logic [1:0]  tdiv = 2'd0;
    logic        tick = 1'b0;
    logic        presetn, psel, penable, pwrite, sleep_req, err;
    logic        cpol, cke, load, sdi, pready, pslverr;
    logic        sck_o, sck_oe, sdo_o, sdo_oe;
    logic [7:0]  paddr, s_tx, s_rx;
    logic [31:0] pwdata, prdata, q;
    logic [1:0]  hold;
    spim_row_s   r;
    int          n_errors, n_tests;
    spim_row_s   rows [6] = '{24'h04a53c, 24'h1c817e, 24'h210ff0,
                              24'h36c35a, 24'h0aff00, 24'h1400ff};
    logic [7:0]  offs [5] = '{CTRL_OFS, STAT_OFS, BUF_OFS, FLAG_OFS, PIN_OFS};

    always #25 pclk = ~pclk;

    always @(posedge pclk)
    begin
        tdiv <= tdiv + 2'd1;
        tick <= (tdiv == 2'd0);
    end

    spim_port uut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sleep_req, .timer_tick(tick),
        .sck_i(1'b0), .sck_o, .sck_oe, .sdo_o, .sdo_oe, .sdi_i(sdi),
        .ss_n_i(1'b1)
    );

    spim_slave_model slv (
        .sck(sck_o), .sdo(sdo_o), .cpol, .cke, .load, .tx(s_tx), .sdi,
        .rx(s_rx)
    );

    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16)
        begin
            n++;
            @(posedge pclk);
        end
        if (n == 16)
            n_errors++;
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cfg(input spim_row_s c);
        apb(1'b1, CTRL_OFS, 32'({2'b00, c.pol, c.mode}));
        apb(1'b1, STAT_OFS, 32'({c.phs, c.edg, 6'h00}));
        apb(1'b1, PIN_OFS, 32'(c.dis));
        apb(1'b1, CTRL_OFS, 32'({2'b01, c.pol, c.mode}));
        cpol <= c.pol;
        cke <= c.edg;
        s_tx <= c.rx;
        load <= 1'b1;
        repeat (2) @(posedge pclk);
        load <= 1'b0;
        chk("sck idle", sck_o, c.pol);
        chk("pin dirs", {sck_oe, sdo_oe}, {1'b1, ~c.dis});
    endtask : cfg

    task automatic done(input spim_row_s c);
        int n;
        n = 0;
        q = '0;
        // Poll with a bound so a stuck flag ends as a mismatch
        while (q[STAT_FULL_BIT] !== 1'b1 && n < 300)
        begin
            apb(1'b0, STAT_OFS, '0);
            n++;
        end
        chk("full set", q[STAT_FULL_BIT], 1'b1);
        apb(1'b0, FLAG_OFS, '0);
        chk("irq flag", q, 32'h1);
        apb(1'b1, FLAG_OFS, 32'h1);
        apb(1'b0, BUF_OFS, '0);
        chk("rx byte", q, 32'(c.rx));
        apb(1'b0, STAT_OFS, '0);
        chk("full clear", q[STAT_FULL_BIT], 1'b0);
        if (!c.dis) chk("tx byte", s_rx, c.tx);
        chk("sck idle end", sck_o, c.pol);
    endtask : done

    task automatic report_and_stop();
        if (n_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////
    initial
    begin
        repeat (50000) @(posedge pclk);
        n_errors++;
        report_and_stop();
    end

    initial
    begin
        {presetn, psel, penable, pwrite, sleep_req, load, cpol, cke} = '0;
        paddr = '0;
        pwdata = '0;
        s_tx = '0;
        n_errors = 0;
        n_tests = 0;
        repeat (20) @(posedge pclk);
        chk("reset pins", {sck_o, sck_oe, sdo_oe}, 32'h0);
        presetn <= 1'b1;
        foreach (offs[i])
        begin
            apb(1'b0, offs[i], '0);
            chk("reset value", q, 32'h0);
        end
        foreach (rows[i])
        begin
            cfg(rows[i]);
            apb(1'b1, BUF_OFS, 32'(rows[i].tx));
            done(rows[i]);
        end
        r = rows[1];
        cfg(r);
        apb(1'b1, BUF_OFS, 32'(r.tx));
        apb(1'b1, BUF_OFS, 32'h99);
        apb(1'b0, CTRL_OFS, '0);
        chk("collision", q[CTRL_COLL_BIT], 1'b1);
        done(r);
        apb(1'b1, CTRL_OFS, 32'({2'b01, r.pol, r.mode}));
        apb(1'b0, CTRL_OFS, '0);
        chk("collision clr", q[CTRL_COLL_BIT], 1'b0);
        cfg(r);
        apb(1'b1, BUF_OFS, 32'(r.tx));
        repeat (40) @(posedge pclk);
        sleep_req <= 1'b1;
        repeat (4) @(posedge pclk);
        hold = {sck_o, sdo_o};
        repeat (80) @(posedge pclk);
        chk("frozen", {sck_o, sdo_o}, hold);
        sleep_req <= 1'b0;
        done(r);
        r = rows[2];
        cfg(r);
        apb(1'b1, BUF_OFS, 32'(r.tx));
        repeat (100) @(posedge pclk);
        apb(1'b1, CTRL_OFS, 32'({2'b00, r.pol, r.mode}));
        // Clock pin settles one cycle after the phase clears
        repeat (3) @(posedge pclk);
        chk("abort idle", {sck_oe, sck_o}, {1'b0, r.pol});
        repeat (600) @(posedge pclk);
        apb(1'b0, STAT_OFS, '0);
        chk("abort no data", q[STAT_FULL_BIT], 1'b0);
        cfg(rows[0]);
        apb(1'b1, BUF_OFS, 32'(rows[0].tx));
        done(rows[0]);
        apb(1'b0, 8'h20, '0);
        chk("bad addr err", err, 1'b1);
        chk("bad addr data", q, 32'h0);
        for (int m = 4; m < 6; m++)
        begin
            apb(1'b1, CTRL_OFS, 32'h20 + 32'(m));
            repeat (2) @(posedge pclk);
            chk("slave clk pin", sck_oe, 1'b0);
        end
        // Slave with a still external clock must not finish a byte
        apb(1'b1, BUF_OFS, 32'h5a);
        repeat (200) @(posedge pclk);
        apb(1'b0, STAT_OFS, '0);
        chk("slave no clock", q[STAT_FULL_BIT], 1'b0);
        report_and_stop();
    end

endmodule : tb_spim_port

`default_nettype wire
